// [include/psm_map.svh]
// register offsets, field positions and reset values of the synchronous memory port
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH
`define PSM_OFS_SEC0 8'h00
`define PSM_OFS_ADDR 8'h10
`define PSM_OFS_WDATA 8'h14
`define PSM_OFS_CTRL 8'h18
`define PSM_OFS_STATUS 8'h1c
`define PSM_OFS_RDATA 8'h20
`define PSM_SEC_RL_LSB 0
`define PSM_SEC_WL_LSB 2
`define PSM_SEC_EXT_BIT 4
`define PSM_SEC_FN_BIT 5
`define PSM_SEC_CLK_BIT 6
`define PSM_SEC_W 7
`define PSM_SEC_RESET 7'h00
`define PSM_CTRL_SPACE_LSB 0
`define PSM_CTRL_WRITE_BIT 2
`define PSM_CTRL_BE_LSB 8
`define PSM_STAT_BUSY_BIT 0
`define PSM_STAT_DONE_BIT 1
`define PSM_LAT_MAX 3
`endif

// [include/psm_pkg.sv]
// types shared by the synchronous memory port
package psm_pkg;
    typedef enum logic {PSM_CLK_ONE, PSM_CLK_TWO} psm_clk_sel_t;
    typedef enum {PSM_IDLE, PSM_ACCESS, PSM_DESEL, PSM_ACK} psm_link_state_t;
endpackage : psm_pkg

// [design/psm_port.sv]
// programmable synchronous memory port: axi4-lite registers and link-side sequencer
//
// Overview of operation
// RULE_01 - read latency 0 to 3, per space
// RULE_02 - write latency 0 to 3, per space
// RULE_03 - extend 0: chip enable drops after command
// RULE_04 - extend 1: chip enable follows output enable
// RULE_05 - strobe as address strobe, with deselect cycle
// RULE_06 - strobe as fifo read enable, no deselect
// RULE_07 - signals sync to selected output clock
// RULE_08 - shared pins take synchronous strobe roles
// RULE_09 - settings from per-space secondary control register
// RULE_10 - read data sampled after read latency cycles
// RULE_11 - write data and byte enables after latency
`timescale 1ns/1ps
`include "psm_map.svh"

module psm_port #(
    parameter int SPACES = 4,
    parameter int ADDR_W = 20,
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output psm_pkg::psm_clk_sel_t syncClockSelect,
    output logic [SPACES-1:0] chipEnableN,
    output logic syncStrobeN,
    output logic syncOutputEnableN,
    output logic syncWriteEnableN,
    output logic [ADDR_W-1:0] memAddr,
    output logic [DATA_W/8-1:0] byteEnableN,
    input wire logic [DATA_W-1:0] memDataIn,
    output logic [DATA_W-1:0] memDataOut,
    output logic memDataOe
);
    import psm_pkg::*;

    localparam int BE_W = DATA_W / 8;

    // refuse shapes the register map cannot carry, at elaboration
    if (SPACES < 1 || SPACES > 4 || ADDR_W < 1 || ADDR_W > 32 || DATA_W < 8 ||
        DATA_W > 32 || DATA_W % 8 != 0) begin : g_bad_shape
        $error("psm_port: unsupported parameter set");
    end

    // merge a bus write into a word under its byte strobes
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldWord,
                                               input logic [31:0] newWord,
                                               input logic [3:0] strb);
        logic [31:0] result;
        result = oldWord;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                result[8*i +: 8] = newWord[8*i +: 8];
            end
        end
        return result;
    endfunction : mergeBytes

    // word index of a secondary control register, or SPACES when not one
    function automatic int secIndex(input logic [7:0] addr);
        int idx;
        idx = SPACES;
        for (int i = 0; i < SPACES; i++) begin
            if (addr == 8'(`PSM_OFS_SEC0 + 4 * i)) begin
                idx = i;
            end
        end
        return idx;
    endfunction : secIndex

    // register domain: bus slave, settings and command launch
    logic [`PSM_SEC_W-1:0] secReg [SPACES];
    logic [31:0] addrReg;
    logic [31:0] wdataReg;
    logic [31:0] rdataReg;
    logic busyReg;
    logic doneReg;
    logic [7:0] awAddrReg;
    logic awHaveReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;
    logic wHaveReg;
    logic reqToggleReg;
    logic ackSync1Reg;
    logic ackSync2Reg;
    logic ackSeenReg;
    // held copy of the launched command, stable until the link answers
    logic [1:0] cmdSpaceReg;
    logic cmdWriteReg;
    logic [BE_W-1:0] cmdBeReg;
    logic [ADDR_W-1:0] cmdAddrReg;
    logic [DATA_W-1:0] cmdDataReg;
    logic [`PSM_SEC_W-1:0] cmdSecReg;
    logic [DATA_W-1:0] linkRdHoldReg;
    logic linkAckToggleReg;

    logic doWrite;
    logic ackEvent;
    logic launch;
    int wIdx;
    assign doWrite = awHaveReg && wHaveReg && !s_axi_bvalid;
    assign ackEvent = ackSync2Reg != ackSeenReg;
    assign wIdx = secIndex(awAddrReg);
    // a command write while busy is dropped so the held command stays stable
    assign launch = doWrite && awAddrReg == `PSM_OFS_CTRL && !busyReg;

    // axi write channels: address and data taken in either order
    always_ff @(posedge clk) begin
        if (rst) begin
            awHaveReg <= 1'b0;
            wHaveReg <= 1'b0;
            awAddrReg <= 8'h00;
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrReg <= s_axi_awaddr;
                awHaveReg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
                wHaveReg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wIdx < SPACES || awAddrReg == `PSM_OFS_ADDR ||
                    awAddrReg == `PSM_OFS_WDATA || awAddrReg == `PSM_OFS_CTRL) ?
                    2'h0 : 2'h2;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHaveReg <= 1'b0;
                wHaveReg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // per-space secondary control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < SPACES; i++) begin
                secReg[i] <= `PSM_SEC_RESET;
            end
        end else if (doWrite && wIdx < SPACES) begin
            secReg[wIdx] <= `PSM_SEC_W'(mergeBytes(32'(secReg[wIdx]), wDataReg, wStrbReg)); // RULE_09
        end
    end

    // address and write data staging registers
    always_ff @(posedge clk) begin
        if (rst) begin
            addrReg <= 32'h0000_0000;
            wdataReg <= 32'h0000_0000;
        end else if (doWrite && awAddrReg == `PSM_OFS_ADDR) begin
            addrReg <= mergeBytes(addrReg, wDataReg, wStrbReg);
        end else if (doWrite && awAddrReg == `PSM_OFS_WDATA) begin
            wdataReg <= mergeBytes(wdataReg, wDataReg, wStrbReg);
        end
    end

    // launch a command and snapshot the space settings it runs under
    always_ff @(posedge clk) begin
        if (rst) begin
            cmdSpaceReg <= 2'h0;
            cmdWriteReg <= 1'b0;
            cmdBeReg <= '0;
            cmdAddrReg <= '0;
            cmdDataReg <= '0;
            cmdSecReg <= `PSM_SEC_RESET;
            reqToggleReg <= 1'b0;
            syncClockSelect <= PSM_CLK_ONE;
        end else if (launch) begin
            cmdSpaceReg <= wDataReg[`PSM_CTRL_SPACE_LSB +: 2];
            cmdWriteReg <= wDataReg[`PSM_CTRL_WRITE_BIT];
            cmdBeReg <= wDataReg[`PSM_CTRL_BE_LSB +: BE_W];
            cmdAddrReg <= addrReg[ADDR_W-1:0];
            cmdDataReg <= wdataReg[DATA_W-1:0];
            cmdSecReg <= secReg[int'(wDataReg[`PSM_CTRL_SPACE_LSB +: 2]) % SPACES]; // RULE_09
            // the outside clock mux feeds linkClk from the chosen output clock
            syncClockSelect <= psm_clk_sel_t'(
                secReg[int'(wDataReg[`PSM_CTRL_SPACE_LSB +: 2]) % SPACES][`PSM_SEC_CLK_BIT]); // RULE_07
            reqToggleReg <= !reqToggleReg;
        end
    end

    // answer from the link: two-stage toggle synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            ackSync1Reg <= 1'b0;
            ackSync2Reg <= 1'b0;
            ackSeenReg <= 1'b0;
        end else begin
            ackSync1Reg <= linkAckToggleReg;
            ackSync2Reg <= ackSync1Reg;
            ackSeenReg <= ackSync2Reg;
        end
    end

    // busy and done status; read data is stable in the link hold register at the answer
    always_ff @(posedge clk) begin
        if (rst) begin
            busyReg <= 1'b0;
            doneReg <= 1'b0;
            rdataReg <= 32'h0000_0000;
        end else if (launch) begin
            busyReg <= 1'b1;
            doneReg <= 1'b0;
        end else if (ackEvent) begin
            busyReg <= 1'b0;
            doneReg <= 1'b1;
            if (!cmdWriteReg) begin
                rdataReg <= 32'(linkRdHoldReg);
            end
        end
    end

    // axi read channel; unmapped offsets answer slverr with zero data
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (secIndex(s_axi_araddr) < SPACES) begin
                s_axi_rdata <= 32'(secReg[secIndex(s_axi_araddr)]);
            end else begin
                unique case (s_axi_araddr)
                    `PSM_OFS_ADDR: s_axi_rdata <= addrReg;
                    `PSM_OFS_WDATA: s_axi_rdata <= wdataReg;
                    `PSM_OFS_CTRL: s_axi_rdata <= 32'h0000_0000;
                    `PSM_OFS_STATUS: s_axi_rdata <= {30'h0, doneReg, busyReg};
                    `PSM_OFS_RDATA: s_axi_rdata <= rdataReg;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // link domain: sequencer and pins, clocked by the selected output clock
    psm_link_state_t state;
    psm_link_state_t stateNext;
    logic [2:0] phaseReg;
    logic [2:0] phaseNext;
    logic reqSync1Reg;
    logic reqSync2Reg;
    logic reqSeenReg;
    logic [1:0] readLat;
    logic [1:0] writeLat;
    logic ceExtend;
    logic fifoMode;
    logic [2:0] lastPhase;

    assign readLat = cmdSecReg[`PSM_SEC_RL_LSB +: 2]; // RULE_01
    assign writeLat = cmdSecReg[`PSM_SEC_WL_LSB +: 2]; // RULE_02
    assign ceExtend = cmdSecReg[`PSM_SEC_EXT_BIT];
    assign fifoMode = cmdSecReg[`PSM_SEC_FN_BIT];
    assign lastPhase = cmdWriteReg ? 3'(writeLat) : 3'(readLat);

    // request toggle synchroniser on the link clock
    always_ff @(posedge linkClk) begin
        if (rst) begin
            reqSync1Reg <= 1'b0;
            reqSync2Reg <= 1'b0;
            reqSeenReg <= 1'b0;
        end else begin
            reqSync1Reg <= reqToggleReg;
            reqSync2Reg <= reqSync1Reg;
            reqSeenReg <= reqSync2Reg;
        end
    end

    // sequencer: phase counts cycles since the command cycle
    always_comb begin
        stateNext = state;
        phaseNext = phaseReg;
        unique case (state)
            PSM_IDLE: begin
                if (reqSync2Reg != reqSeenReg) begin
                    stateNext = PSM_ACCESS;
                    phaseNext = 3'h0;
                end
            end
            PSM_ACCESS: begin
                if (phaseReg == lastPhase) begin
                    stateNext = fifoMode ? PSM_ACK : PSM_DESEL; // RULE_05 RULE_06
                end else begin
                    phaseNext = phaseReg + 3'h1;
                end
            end
            PSM_DESEL: stateNext = PSM_ACK;
            PSM_ACK: stateNext = PSM_IDLE;
        endcase
    end

    // state, read capture and answer toggle
    always_ff @(posedge linkClk) begin
        if (rst) begin
            state <= PSM_IDLE;
            phaseReg <= 3'h0;
            linkRdHoldReg <= '0;
            linkAckToggleReg <= 1'b0;
        end else begin
            state <= stateNext;
            phaseReg <= phaseNext;
            if (state == PSM_ACCESS && !cmdWriteReg && phaseReg == 3'(readLat)) begin
                linkRdHoldReg <= memDataIn; // RULE_10
            end
            if (state == PSM_ACK) begin
                linkAckToggleReg <= !linkAckToggleReg;
            end
        end
    end

    // pin values for the cycle about to start, registered so pins leave flops
    logic inAccess;
    logic isRead;
    logic readOpen;
    assign inAccess = stateNext == PSM_ACCESS;
    assign isRead = inAccess && !cmdWriteReg;
    assign readOpen = isRead && phaseNext <= 3'(readLat);

    always_ff @(posedge linkClk) begin
        if (rst) begin
            chipEnableN <= '1;
            syncStrobeN <= 1'b1;
            syncOutputEnableN <= 1'b1;
            syncWriteEnableN <= 1'b1;
            memAddr <= '0;
            byteEnableN <= '1;
            memDataOut <= '0;
            memDataOe <= 1'b0;
        end else begin
            for (int i = 0; i < SPACES; i++) begin
                chipEnableN[i] <= !(int'(cmdSpaceReg) % SPACES == i && inAccess &&
                    (phaseNext == 3'h0 || (ceExtend && readOpen))); // RULE_03 RULE_04
            end
            // strobe: address strobe on every command and on the deselect cycle,
            // read enable only on reads in fifo mode
            syncStrobeN <= !((inAccess && phaseNext == 3'h0 && (isRead || !fifoMode)) ||
                stateNext == PSM_DESEL); // RULE_05 RULE_06 RULE_08
            syncOutputEnableN <= !readOpen; // RULE_08
            syncWriteEnableN <= !(inAccess && cmdWriteReg && phaseNext == 3'h0); // RULE_08
            memAddr <= cmdAddrReg;
            memDataOut <= cmdDataReg;
            memDataOe <= inAccess && cmdWriteReg && phaseNext == 3'(writeLat); // RULE_11
            if (inAccess && (isRead ? phaseNext <= 3'(readLat) : phaseNext == 3'(writeLat))) begin
                byteEnableN <= ~cmdBeReg; // RULE_11
            end else begin
                byteEnableN <= '1;
            end
        end
    end
endmodule : psm_port

// [verif/psm_port_monitor.sv]
// concurrent checks on the register bus and memory link of psm_port
`timescale 1ns/1ps
module psm_port_monitor #(
    parameter int SPACES = 4,
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire psm_pkg::psm_clk_sel_t syncClockSelect,
    input wire logic [SPACES-1:0] chipEnableN,
    input wire logic syncStrobeN,
    input wire logic syncOutputEnableN,
    input wire logic syncWriteEnableN,
    input wire logic [DATA_W/8-1:0] byteEnableN,
    input wire logic memDataOe
);
    import psm_pkg::*;
    // a read keeps output enable low for latency plus one cycles, four at most
    sequence oeRelease;
        ##[1:4] syncOutputEnableN;
    endsequence
    // write data follows its command within the largest write latency
    sequence dataPhase;
        ##[0:3] memDataOe;
    endsequence
    read_window_a: assert property (@(posedge linkClk) disable iff (rst)
        $fell(syncOutputEnableN) |-> oeRelease) else $error("read window too long");
    write_data_a: assert property (@(posedge linkClk) disable iff (rst)
        $fell(syncWriteEnableN) |-> dataPhase) else $error("write data late");
    ce_cause_a: assert property (@(posedge linkClk) disable iff (rst)
        chipEnableN != '1 |-> !syncOutputEnableN || !syncWriteEnableN)
        else $error("chip enable without command");
    deselect_a: assert property (@(posedge linkClk) disable iff (rst)
        !syncStrobeN && chipEnableN == '1 |=> syncStrobeN) else $error("deselect too long");
    clock_hold_a: assert property (@(posedge linkClk) disable iff (rst)
        !syncOutputEnableN || !syncWriteEnableN |-> $stable(syncClockSelect))
        else $error("clock select moved");
    pin_roles_a: assert property (@(posedge linkClk) disable iff (rst)
        !syncWriteEnableN |-> (syncOutputEnableN && chipEnableN != '1) ##1 syncWriteEnableN)
        else $error("write strobe roles");
    data_be_a: assert property (@(posedge linkClk) disable iff (rst)
        memDataOe |-> (byteEnableN != '1) ##1 !memDataOe) else $error("data cycle");
    read_answer_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    resp_hold_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
endmodule : psm_port_monitor

bind psm_port psm_port_monitor #(.SPACES(SPACES), .DATA_W(DATA_W)) u_monitor (
    .clk, .rst, .linkClk, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
    .s_axi_bready, .syncClockSelect, .chipEnableN, .syncStrobeN, .syncOutputEnableN,
    .syncWriteEnableN, .byteEnableN, .memDataOe
);

// [verif/psm_mem_model.sv]
// behavioural synchronous memory answering the port's link
`timescale 1ns/1ps
module psm_mem_model (
    input wire logic linkClk,
    input wire logic [1:0] readLat,
    input wire logic [3:0] chipEnableN,
    input wire logic syncStrobeN,
    input wire logic syncOutputEnableN,
    input wire logic [19:0] memAddr,
    input wire logic [3:0] byteEnableN,
    input wire logic [31:0] memDataOut,
    input wire logic memDataOe,
    output logic [31:0] memDataIn
);
    logic [31:0] words [16];
    logic [31:0] word;
    logic [2:0] phase = 3'd0;
    logic inRead = 1'b0;
    logic start;
    logic hit;
    // a read command is chip enable, strobe and output enable low together
    assign start = !inRead && chipEnableN != 4'hf && !syncStrobeN && !syncOutputEnableN;
    assign hit = start ? readLat == 2'd0 : inRead && phase == {1'b0, readLat};
    assign word = words[memAddr[3:0]];
    // off the data cycle the bus shows the inverse, so an early or late sample fails
    assign memDataIn = hit ? word : ~word;
    // track the read phase; take write data only in its own cycle
    always @(posedge linkClk) begin
        phase <= start ? 3'd1 : phase + 3'd1;
        inRead <= start || (inRead && !syncOutputEnableN);
        for (int b = 0; b < 4; b++) begin
            if (memDataOe && !byteEnableN[b]) begin
                words[memAddr[3:0]][8*b+:8] <= memDataOut[8*b+:8];
            end
        end
    end
endmodule : psm_mem_model

// [verif/psm_port_tb.sv]
// self-checking bench for psm_port against a behavioural memory
`timescale 1ns/1ps
module psm_port_tb;
    import psm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic linkClk = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, memDataIn, memDataOut, st;
    psm_clk_sel_t syncClockSelect;
    logic [3:0] chipEnableN, byteEnableN, idx;
    logic syncStrobeN, syncOutputEnableN, syncWriteEnableN, memDataOe;
    logic [19:0] memAddr;
    logic [1:0] readLat = 2'd0;
    logic [31:0] shadow [16];
    logic [34:0] expR [$];
    logic [1:0] expB [$];
    logic [34:0] note;
    logic [3:0] ceMask = 4'h0;
    logic [6:0] sec;
    int miscompares = 0;
    int checksDone = 0;
    int oeCnt = 0, ceCnt = 0, deselCnt = 0, wl = 0, gap = 0;

    // bus clock; the link clock is offset so its edges never meet the bus clock
    always #2 clk = ~clk;
    initial begin
        #13;
        forever #40 linkClk = ~linkClk;
    end

    psm_port dut (.clk, .rst, .linkClk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .syncClockSelect, .chipEnableN,
        .syncStrobeN, .syncOutputEnableN, .syncWriteEnableN, .memAddr, .byteEnableN,
        .memDataIn, .memDataOut, .memDataOe);
    psm_mem_model mem (.linkClk, .readLat, .chipEnableN, .syncStrobeN, .syncOutputEnableN,
        .memAddr, .byteEnableN, .memDataOut, .memDataOe, .memDataIn);

    task chk(input logic [33:0] seen, input logic [33:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wrap_up;
        if (miscompares == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // one write: address and data offered together, each released when taken
    task axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw;
        logic w;
        @(posedge clk);
        aw = 1'b1;
        w = 1'b1;
        expB.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        // a late bready now and then makes the slave hold its response
        repeat ($urandom_range(2, 0)) @(posedge clk);
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axiWr

    // one read; bit 34 of the note says whether the answer is compared
    task axiRd(input logic [7:0] a, input logic [34:0] e, output logic [31:0] d);
        @(posedge clk);
        expR.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : axiRd

    // launch one link access, try a second launch while busy, then judge the link
    task access(input int sp, input logic wr, input logic [3:0] be, input logic [31:0] wd);
        logic [3:0] rlp;
        rlp = 4'(sec[1:0]) + 4'd1;
        axiWr(8'h10, {28'h0, idx}, 2'b00);
        axiWr(8'h14, wd, 2'b00);
        {oeCnt, ceCnt, deselCnt, wl, ceMask} = '0;
        axiWr(8'h18, {20'h0, be, 5'h0, wr, 2'(sp)}, 2'b00);
        axiWr(8'h18, {20'h0, be, 5'h0, ~wr, 2'(sp)}, 2'b00);
        do axiRd(8'h1c, 35'h0, st); while (st[0]);
        chk(34'(st[1]), 34'h1);
        chk(34'({oeCnt[3:0], ceCnt[3:0], deselCnt[3:0], ceMask}), 34'({wr ? 4'd0 : rlp,
            (wr || !sec[4]) ? 4'd1 : rlp, sec[5] ? 4'd0 : 4'd1, 4'd1 << sp}));
        chk(34'(syncClockSelect), 34'(sec[6]));
        if (wr) begin
            chk(34'(wl), 34'(sec[3:2]));
            for (int b = 0; b < 4; b++) if (be[b]) shadow[idx][8*b+:8] = wd[8*b+:8];
        end else begin
            axiRd(8'h20, {3'b100, shadow[idx]}, st);
        end
    endtask : access

    // answers on the bus are taken in order against the driver's notes
    always @(posedge clk) begin
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(expB.pop_front()));
        if (s_axi_rvalid && s_axi_rready) begin
            note = expR.pop_front();
            if (note[35-1]) chk({s_axi_rresp, s_axi_rdata}, note[33:0]);
        end
    end

    // link activity counters, cleared by the driver before each launch
    always @(posedge linkClk) begin
        if (!syncOutputEnableN) oeCnt++;
        if (chipEnableN != 4'hf) ceCnt++;
        if (!syncStrobeN && chipEnableN == 4'hf) deselCnt++;
        ceMask = ceMask | ~chipEnableN;
        gap = syncWriteEnableN ? gap + 1 : 0;
        if (memDataOe) wl = gap;
    end

    // a hang counts against the run
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        wrap_up();
    end

    // reset must span link edges too, then sweep every latency and mode
    initial begin
        void'($urandom(32'h9c70));
        repeat (16) @(posedge clk);
        repeat (3) @(posedge linkClk);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(34'({chipEnableN, syncStrobeN, syncOutputEnableN, syncWriteEnableN, memDataOe}),
            34'h0fe);
        axiRd(8'h0c, {1'b1, 34'h0}, st);
        axiRd(8'h18, {1'b1, 34'h0}, st);
        axiWr(8'h40, 32'h1, 2'b10);
        axiRd(8'h40, {1'b1, 2'b10, 32'h0}, st);
        for (int i = 0; i < 8; i++) begin
            sec = {i[1], i[0] ^ i[2], i[2], ~i[1:0], i[1:0]};
            readLat = sec[1:0];
            idx = 4'($urandom);
            axiWr(8'(4 * (i % 4)), {25'h0, sec}, 2'b00);
            axiRd(8'(4 * (i % 4)), {3'b100, 25'h0, sec}, st);
            access(i % 4, 1'b1, 4'hf, $urandom);
            access(i % 4, 1'b1, 4'($urandom_range(15, 1)), $urandom);
            access(i % 4, 1'b0, 4'hf, 32'h0);
        end
        wrap_up();
    end
endmodule : psm_port_tb
